// ### sysctl_irq_pkg.sv
// Constants, field layouts and carrier types for the system-control interrupt block
package sysctl_irq_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADR_W = 12;
	localparam int EVT_N = 7;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] RAW_OFS   = 12'h050;
	localparam logic [11:0] MASK_OFS  = 12'h054;
	localparam logic [11:0] MSTAT_OFS = 12'h058;
	localparam logic [11:0] BOCTL_OFS = 12'h0A0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PLL_LOCK_BIT   = 6;
	localparam int CUR_LIMIT_BIT  = 5;
	localparam int INT_OSC_BIT    = 4;
	localparam int MAIN_OSC_BIT   = 3;
	localparam int REG_UNREG_BIT  = 2;
	localparam int BROWNOUT_BIT   = 1;
	localparam int PLL_FAULT_BIT  = 0;
	localparam int BOSEL_BIT      = 1;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [6:0]  MASK_RST  = 7'h00;
	localparam logic [6:0]  RAW_RST   = 7'h00;
	localparam logic        BOSEL_RST = 1'b0;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// Event vector, bit 6 down to bit 0
	typedef struct packed {
		logic pll_lock;
		logic current_limit;
		logic internal_osc_fault;
		logic main_osc_fault;
		logic regulator_unregulated;
		logic brownout;
		logic pll_fault;
	} evt_t;

	// Classic Wishbone request bundle
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

endpackage

// ### sticky_event_bit.sv
// One sticky status bit: hardware sets, software clears, set wins
`timescale 1ns/100ps
module sticky_event_bit #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      q_o
);

	logic q_r;
	logic q_nxt;

	// Set beats clear so an event landing on a clear is kept
	assign q_nxt = set_i | (q_r & ~clr_i);

	// State update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= RST_VAL;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;

endmodule

// ### sysctl_reg_decode.sv
// Address decode for the system-control interrupt registers
`timescale 1ns/100ps
module sysctl_reg_decode
	import sysctl_irq_pkg::*;
(
	input  wire logic [11:0] adr_i,
	output logic             raw_hit_o,
	output logic             mask_hit_o,
	output logic             mstat_hit_o,
	output logic             boctl_hit_o,
	output logic             unmapped_o
);

	// Word compare; byte offset bits are ignored
	assign raw_hit_o   = (adr_i[11:2] == RAW_OFS[11:2]);
	assign mask_hit_o  = (adr_i[11:2] == MASK_OFS[11:2]);
	assign mstat_hit_o = (adr_i[11:2] == MSTAT_OFS[11:2]);
	assign boctl_hit_o = (adr_i[11:2] == BOCTL_OFS[11:2]);

	// Unmapped words still get an ack, reading zero
	assign unmapped_o  = ~(raw_hit_o | mask_hit_o | mstat_hit_o | boctl_hit_o);

endmodule

// ### sysctl_irq.sv
// System-control event masking, masked status and interrupt request
`timescale 1ns/100ps

module sysctl_irq
	import sysctl_irq_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [6:0]  event_i,
	output logic             irq_o,
	output logic             brownout_reset_sel_o
);

	// ----------------------------------------------------------------
	// Bus request bundle
	// ----------------------------------------------------------------
	wb_req_t req;

	assign req.cyc = wb_cyc_i;
	assign req.stb = wb_stb_i;
	assign req.we  = wb_we_i;
	assign req.adr = wb_adr_i;
	assign req.sel = wb_sel_i;
	assign req.dat = wb_dat_i;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	logic [6:0]  mask_r;
	logic [6:0]  mask_nxt;
	logic        bosel_r;
	logic        bosel_nxt;
	evt_t        raw_q;
	evt_t        mask_q;
	evt_t        masked_q;
	logic [6:0]  raw_w;
	logic [6:0]  masked_w;
	logic [6:0]  bosel_gate;
	logic [6:0]  w1c_w;
	logic        raw_hit;
	logic        mask_hit;
	logic        mstat_hit;
	logic        boctl_hit;
	logic        unmapped;
	logic        req_new;
	logic        rd_new;
	logic        wr_go;
	logic        lane0_wr;
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	sysctl_reg_decode u_decode (
		.adr_i       (req.adr),
		.raw_hit_o   (raw_hit),
		.mask_hit_o  (mask_hit),
		.mstat_hit_o (mstat_hit),
		.boctl_hit_o (boctl_hit),
		.unmapped_o  (unmapped)
	);

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// New request seen while ack low; ack drops the cycle after it rose
	assign req_new = req.cyc & req.stb & ~ack_r;
	assign rd_new  = req_new & ~req.we;
	assign ack_nxt = req_new;

	// Writes land on the edge that the master samples ack
	assign wr_go    = req.cyc & req.stb & req.we & ack_r;
	// Only byte lane 0 carries live bits
	assign lane0_wr = wr_go & req.sel[0];

	// Ack register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
		end
	end

	assign wb_ack_o = ack_r;

	// ----------------------------------------------------------------
	// Mask and brown-out control registers
	// ----------------------------------------------------------------
	// Upper data bits are dropped so reserved mask bits never store
	assign mask_nxt  = (lane0_wr & mask_hit) ? req.dat[6:0] : mask_r;
	assign bosel_nxt = (lane0_wr & boctl_hit) ? req.dat[BOSEL_BIT] : bosel_r;

	// Control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r  <= MASK_RST;
			bosel_r <= BOSEL_RST;
		end else begin
			mask_r  <= mask_nxt;
			bosel_r <= bosel_nxt;
		end
	end

	assign mask_q               = evt_t'(mask_r);
	assign brownout_reset_sel_o = bosel_r;

	// ----------------------------------------------------------------
	// Raw event status
	// ----------------------------------------------------------------
	// Clear strobes from a one written to the masked status word;
	// raw clears too, even if its mask bit is off
	assign w1c_w = (lane0_wr & mstat_hit) ? req.dat[6:0] : 7'h00;

	// Raw bits only take event set and the W1C clear; no direct write
	for (genvar g = 0; g < EVT_N; g++) begin : g_raw
		sticky_event_bit #(
			.RST_VAL (RAW_RST[g])
		) u_bit (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.set_i (event_i[g]),
			.clr_i (w1c_w[g]),
			.q_o   (raw_w[g])
		);
	end

	assign raw_q = evt_t'(raw_w);

	// ----------------------------------------------------------------
	// Masked status and interrupt
	// ----------------------------------------------------------------
	// Brown-out routed to reset instead hides its interrupt
	assign bosel_gate = ~(7'(bosel_r) << BROWNOUT_BIT);

	// Per-bit AND, shared by read-back and interrupt
	assign masked_w = raw_w & mask_r & bosel_gate;
	assign masked_q = evt_t'(masked_w);

	// Combinational level from flops; no extra latency on the request
	assign irq_o = |masked_w;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Reserved bits and unmapped words read zero
	assign rd_mux = raw_hit   ? {25'h000_0000, raw_w}    :
	                mask_hit  ? {25'h000_0000, mask_r}   :
	                mstat_hit ? {25'h000_0000, masked_w} :
	                boctl_hit ? (32'(bosel_r) << BOSEL_BIT) :
	                ZERO_WORD;

	// Data is captured with ack so it stands for the ack cycle
	assign rdat_nxt = rd_new ? rd_mux : rdat_r;

	// Read data register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= ZERO_WORD;
		end else begin
			rdat_r <= rdat_nxt;
		end
	end

	assign wb_dat_o = rdat_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Each source alone must raise the request
	pll_lock_irq_a: assert property (
		(raw_q.pll_lock && mask_q.pll_lock) |-> irq_o
	) else $error("PLL lock event masked in but no irq");

	cur_limit_irq_a: assert property (
		(raw_q.current_limit && mask_q.current_limit) |-> irq_o
	) else $error("Current limit event masked in but no irq");

	int_osc_irq_a: assert property (
		(raw_q.internal_osc_fault && !mask_q.internal_osc_fault) |->
			!masked_q.internal_osc_fault
	) else $error("Internal osc fault passes a cleared mask");

	int_osc_raise_a: assert property (
		(raw_q.internal_osc_fault && mask_q.internal_osc_fault) |-> irq_o
	) else $error("Internal osc fault masked in but no irq");

	main_osc_irq_a: assert property (
		masked_q.main_osc_fault == (raw_q.main_osc_fault && mask_q.main_osc_fault)
	) else $error("Main osc fault masked bit wrong");

	main_osc_raise_a: assert property (
		masked_q.main_osc_fault |-> irq_o
	) else $error("Main osc fault masked bit set but no irq");

	// A rise needs the bit armed now and a raw cause one edge back;
	// arming the mask over an old raw bit is a legal cause too
	reg_unreg_irq_a: assert property (
		$rose(masked_q.regulator_unregulated) |->
			irq_o && mask_r[REG_UNREG_BIT] &&
			$past(raw_w[REG_UNREG_BIT] | event_i[REG_UNREG_BIT])
	) else $error("Regulator unregulated rose without cause");

	reg_unreg_raise_a: assert property (
		(raw_q.regulator_unregulated && mask_q.regulator_unregulated) |-> irq_o
	) else $error("Regulator unregulated masked in but no irq");

	brownout_irq_a: assert property (
		(raw_q.brownout && mask_q.brownout && !bosel_r) |-> irq_o
	) else $error("Brown-out interrupt missing");

	pll_fault_irq_a: assert property (
		(event_i[PLL_FAULT_BIT] && mask_r[PLL_FAULT_BIT] && !wr_go) |=> irq_o
	) else $error("PLL fault event did not raise irq next cycle");

	// Read of masked status returns the AND captured at request
	mstat_read_a: assert property (
		(rd_new && mstat_hit) |=>
			wb_ack_o && wb_dat_o == 32'($past(raw_w & mask_r & bosel_gate))
	) else $error("Masked status read data wrong");

	// Written ones clear raw unless the same bit fires again
	w1c_clear_a: assert property (
		(lane0_wr && mstat_hit) |=>
			(raw_w & $past(wb_dat_i[6:0]) & ~$past(event_i)) == 7'h00
	) else $error("W1C did not clear raw bit");

	// A raw bit only drops on a written one
	raw_keep_a: assert property (
		(raw_w != 7'h00) |=> ($past(raw_w & ~w1c_w) & ~raw_w) == 7'h00
	) else $error("Raw bit dropped without a clear");

	// Reserved mask bits read zero
	mask_rsvd_a: assert property (
		(rd_new && mask_hit) |=> wb_dat_o[31:7] == 25'h0
	) else $error("Reserved mask bits read nonzero");

	// Mask takes the low seven data bits of an accepted write
	mask_write_a: assert property (
		(lane0_wr && mask_hit) |=> mask_r == $past(wb_dat_i[6:0])
	) else $error("Mask write did not land");

	mask_hold_a: assert property (
		!(lane0_wr && mask_hit) |=> $stable(mask_r)
	) else $error("Mask changed without a write");

	// Lane 0 off means the write carries no live bits
	sel_lane_a: assert property (
		(wr_go && !req.sel[0]) |=> $stable(mask_r) && $stable(bosel_r)
	) else $error("Write without lane 0 changed a register");

	// A raw bit never appears without its event
	raw_hw_only_a: assert property (
		((raw_w & ~$past(raw_w)) & ~$past(event_i)) == 7'h00
	) else $error("Raw bit set without event");

	// An event lands on the next edge, even against a clear
	event_set_a: assert property (
		(event_i != 7'h00) |=> (raw_w & $past(event_i)) == $past(event_i)
	) else $error("Event did not set its raw bit");

	// Raw word reads back as it stood when the read was taken
	raw_read_a: assert property (
		(rd_new && raw_hit) |=> wb_dat_o == 32'($past(raw_w))
	) else $error("Raw status read data wrong");

	brownout_sel_a: assert property (
		bosel_r |-> !masked_q.brownout
	) else $error("Brown-out irq shown while routed to reset");

	bosel_write_a: assert property (
		(lane0_wr && boctl_hit) |=> bosel_r == $past(wb_dat_i[BOSEL_BIT])
	) else $error("Brown-out select write did not land");

	// Request stays up while any masked bit holds with no write
	irq_hold_a: assert property (
		(irq_o && !wr_go && mask_r == $past(mask_r)) |=> irq_o ##0 (masked_w != 7'h00)
	) else $error("Irq dropped without a clear");

	// No masked bit, no request
	irq_quiet_a: assert property (
		(masked_w == 7'h00) |-> !irq_o
	) else $error("Irq high with no masked bit set");

	// ----------------------------------------------------------------
	// Bus answer checks
	// ----------------------------------------------------------------
	// Every new request is answered on the next edge, never twice
	ack_answer_a: assert property (
		(req.cyc && req.stb && !wb_ack_o) |=> wb_ack_o
	) else $error("Request not answered next cycle");

	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("Ack held for more than one cycle");

	// Holes in the map read as zero
	unmapped_read_a: assert property (
		(rd_new && unmapped) |=> wb_dat_o == ZERO_WORD
	) else $error("Unmapped read returned data");

	// Read data stands until the next read is taken
	rdat_hold_a: assert property (
		!rd_new |=> $stable(wb_dat_o)
	) else $error("Read data moved without a read");

	// Main scenarios
	irq_rise_c:   cover property ($rose(irq_o));
	w1c_drop_c:   cover property (irq_o ##1 (lane0_wr && mstat_hit) ##1 !irq_o);
	mstat_read_c: cover property (rd_new && mstat_hit && masked_w != 7'h00);
	bosel_hide_c: cover property (bosel_r && raw_q.brownout && mask_q.brownout);
	mask_arm_c:   cover property (lane0_wr && mask_hit && raw_w != 7'h00);

endmodule

// ### sysctl_irq_partner.sv
// Behavioural model of the interrupt controller that receives the request
`timescale 1ns/100ps
module sysctl_irq_partner (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic irq_i,
	input  wire logic take_i,
	output logic      pend_o
);

	// ----------------------------------------------------------------
	// Pending latch
	// ----------------------------------------------------------------
	// Level request sampled each edge; taking it only sticks once the level drops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_o <= 1'b0;
		end else begin
			pend_o <= irq_i | (pend_o & ~take_i);
		end
	end

endmodule

// ### sysctl_interrupt_mask_status_tb.sv
// Self-checking bench for the system-control interrupt mask and status block
`timescale 1ns/100ps
module sysctl_interrupt_mask_status_tb;
	import sysctl_irq_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [6:0] mask;
		logic [6:0] evt;
		logic [6:0] exp_ms;
		logic       exp_irq;
	} row_t;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	wb_req_t     req = '0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [6:0]  event_i = 7'h00;
	logic        irq_o;
	logic        brownout_reset_sel_o;
	logic        pend_o;
	logic        take_i = 1'b0;
	logic [31:0] rd;
	row_t        rows [14];
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;

	sysctl_irq u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
		.wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_i(event_i), .irq_o(irq_o),
		.brownout_reset_sel_o(brownout_reset_sel_o)
	);

	sysctl_irq_partner u_pic (
		.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .take_i(take_i), .pend_o(pend_o)
	);

	// Clock and hang guard; the whole run needs well under 2000 cycles
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Classic cycle; request held until the rising edge that sees ack,
	// where read data is taken and the request released
	task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
			input logic [3:0] sel = 4'hF);
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		req <= '0;
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, ZERO_WORD);
		chk32(rd, exp);
	endtask

	task automatic irq_chk(input logic exp);
		@(negedge clk_i);
		chk1(irq_o, exp);
	endtask

	// One-cycle event pulse; raw bit lands on the second edge
	task automatic pulse(input logic [6:0] v);
		@(posedge clk_i);
		event_i <= v;
		@(posedge clk_i);
		event_i <= 7'h00;
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(MASK_OFS, ZERO_WORD);
		rd_chk(RAW_OFS, ZERO_WORD);
		irq_chk(1'b0);
		// Each event alone, once enabled and once with every other mask bit set
		for (int k = 0; k < 7; k++) begin
			rows[2 * k] = '{7'h01 << k, 7'h01 << k, 7'h01 << k, 1'b1};
			rows[2 * k + 1] = '{~(7'h01 << k), 7'h01 << k, 7'h00, 1'b0};
		end
		foreach (rows[i]) begin
			wb(1'b1, MASK_OFS, 32'(rows[i].mask));
			pulse(rows[i].evt);
			rd_chk(MSTAT_OFS, 32'(rows[i].exp_ms));
			irq_chk(rows[i].exp_irq);
			rd_chk(RAW_OFS, 32'(rows[i].evt));
			wb(1'b1, MSTAT_OFS, 32'h0000_007F);
			rd_chk(RAW_OFS, ZERO_WORD);
		end
		// Brown-out routed to reset gives no interrupt until the select clears
		@(posedge clk_i);
		take_i <= 1'b1;
		@(posedge clk_i);
		take_i <= 1'b0;
		wb(1'b1, BOCTL_OFS, 32'h0000_0002);
		wb(1'b1, MASK_OFS, 32'h0000_0002);
		chk1(brownout_reset_sel_o, 1'b1);
		pulse(7'h02);
		rd_chk(MSTAT_OFS, ZERO_WORD);
		irq_chk(1'b0);
		chk1(pend_o, 1'b0);
		wb(1'b1, BOCTL_OFS, ZERO_WORD);
		irq_chk(1'b1);
		// Reserved mask bits, zero writes, raw writes and partial clears
		wb(1'b1, MASK_OFS, 32'hFFFF_FFFF);
		chk1(pend_o, 1'b1);
		rd_chk(MASK_OFS, 32'h0000_007F);
		pulse(7'h41);
		wb(1'b1, MSTAT_OFS, ZERO_WORD);
		rd_chk(MSTAT_OFS, 32'h0000_0043);
		wb(1'b1, RAW_OFS, ZERO_WORD);
		rd_chk(RAW_OFS, 32'h0000_0043);
		wb(1'b1, MSTAT_OFS, 32'h0000_0003);
		irq_chk(1'b1);
		wb(1'b1, MSTAT_OFS, 32'h0000_0040);
		irq_chk(1'b0);
		rd_chk(12'h100, ZERO_WORD);
		// Byte lane 0 off: the write must leave the mask alone
		wb(1'b1, MASK_OFS, ZERO_WORD, 4'hE);
		rd_chk(MASK_OFS, 32'h0000_007F);
		// Reset in mid-run with an interrupt pending
		pulse(7'h10);
		irq_chk(1'b1);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		irq_chk(1'b0);
		rd_chk(MASK_OFS, ZERO_WORD);
		rd_chk(RAW_OFS, ZERO_WORD);
		conclude();
	end

endmodule
